// File: irq_input_cfg.svh
// timing counts, field widths, set value limits and latch codes for the interrupt input unit
// assumes inclusion by the package and the unit; holds definitions only
`ifndef IRQ_INPUT_CFG_SVH
`define IRQ_INPUT_CFG_SVH

`define IRQ_NUM_INPUTS      8
`define IRQ_COUNT_WIDTH     16
`define IRQ_TASK_BASE       8'h8c
`define IRQ_SET_MIN         16'h0001
`define IRQ_SET_MAX         16'hffff
`define IRQ_RESP_FREQ_HZ    3000
`define IRQ_CLK_FREQ_HZ     100000000
// least input high or low time at the rated rate, in clock cycles
`define IRQ_MIN_HALF_CYC    (`IRQ_CLK_FREQ_HZ / (2 * `IRQ_RESP_FREQ_HZ))
`define IRQ_SCAN_PERIOD_CYC 1000
`define IRQ_LATCH_NONE      4'h0
`define IRQ_LATCH_PULSE0    4'h1
`define IRQ_LATCH_COUNTER0  4'h5
`define IRQ_LATCH_LAST      4'h8

`endif

// File: irq_input_pkg.sv
// types shared by the interrupt input unit and its surroundings
// assumes the cfg header for all figures
`include "irq_input_cfg.svh"

package irq_input_pkg;

  // how an input reacts to its chosen edge
  typedef enum logic [1:0] {
    MODE_DIRECT,
    MODE_COUNT_UP,
    MODE_COUNT_DOWN,
    MODE_MASKED
  } irq_mode_t;

  // one mask-set command as issued by the program
  typedef struct packed {
    logic [2:0] input_sel;
    irq_mode_t  mode;
    logic       edge_valid;
    logic       edge_falling;
  } mask_set_cmd_t;

  // one raised request towards the task scheduler
  typedef struct packed {
    logic [7:0]  task_num;
    logic [2:0]  input_sel;
  } task_start_t;

endpackage

// File: edge_interrupt_input_unit.sv
// eight edge interrupt inputs with direct and counter modes and latches
// assumes command strobes synchronous to clk_sys_in; field inputs pass a two-stage synchroniser
`timescale 1ns/1ps
`include "irq_input_cfg.svh"

module edge_interrupt_input_unit
  import irq_input_pkg::*;
#(
  parameter int N_IN  = `IRQ_NUM_INPUTS,
  parameter int CW    = `IRQ_COUNT_WIDTH,
  parameter int SCAN  = `IRQ_SCAN_PERIOD_CYC
)(
  // clock and reset
  input  wire logic                   clk_sys_in,
  input  wire logic                   reset_n_in,
  // field inputs, low nibbles of the two module input words
  input  wire logic [3:0]             module0_input_word_in,
  input  wire logic [3:0]             module1_input_word_in,
  // stored configuration
  input  wire logic [N_IN-1:0]        cfg_irq_select_in,
  input  wire logic [N_IN-1:0]        cfg_edge_falling_in,
  input  wire logic [N_IN*4-1:0]      cfg_latch_src_in,
  input  wire logic                   run_mode_in,
  // set values, one per input
  input  wire logic [N_IN*CW-1:0]     count_set_words_in,
  // program commands
  input  wire logic                   interrupt_mask_set_command_in,
  input  wire mask_set_cmd_t          mask_set_in,
  input  wire logic                   global_irq_disable_command_in,
  input  wire logic                   global_irq_enable_command_in,
  input  wire logic                   live_value_read_command_in,
  input  wire logic [2:0]             live_value_sel_in,
  // latch sources: four pulse outputs then four fast counters
  input  wire logic [8*32-1:0]        latch_source_values_in,
  // requests and values
  output logic                        task_start_out,
  output task_start_t                 task_info_out,
  output logic [N_IN*CW-1:0]          count_present_words_out,
  output logic [CW-1:0]               live_value_out,
  output logic                        live_value_valid_out,
  output logic [N_IN*32-1:0]          latch_store_words_out,
  output logic [N_IN-1:0]             latch_valid_out
);

  // ---------------------------------------------------------------
  // input sampling
  // ---------------------------------------------------------------
  logic [N_IN-1:0] raw_in;
  logic [N_IN-1:0] sync1_ff;
  logic [N_IN-1:0] sync2_ff;
  logic [N_IN-1:0] prev_ff;

  assign raw_in = {module1_input_word_in, module0_input_word_in};

  // two stages then one history stage; sync2 and the history stage feed the detector
  always_ff @(posedge clk_sys_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      sync1_ff <= '0;
      sync2_ff <= '0;
      prev_ff  <= '0;
    end
    else
    begin
      sync1_ff <= raw_in;
      sync2_ff <= sync1_ff;
      prev_ff  <= sync2_ff;
    end
  end

  // ---------------------------------------------------------------
  // per input mode and edge
  // ---------------------------------------------------------------
  irq_mode_t       mode_ff [N_IN];
  logic [N_IN-1:0] falling_ff;
  logic            run_prev_ff;
  logic            run_start;

  assign run_start = run_mode_in && !run_prev_ff;

  always_ff @(posedge clk_sys_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      run_prev_ff <= 1'b0;
    else
      run_prev_ff <= run_mode_in;
  end

  // mask-set command chooses mode and may change the edge at any time
  always_ff @(posedge clk_sys_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      falling_ff <= '0;
      for (int i = 0; i < N_IN; i++)
        mode_ff[i] <= MODE_MASKED;
    end
    else
    begin
      if (run_start)
        falling_ff <= cfg_edge_falling_in;
      if (interrupt_mask_set_command_in)
      begin
        mode_ff[mask_set_in.input_sel] <= mask_set_in.mode;
        if (mask_set_in.edge_valid)
          falling_ff[mask_set_in.input_sel] <=
            mask_set_in.edge_falling;
      end
    end
  end

  // edge events; unselected terminals serve another function
  logic [N_IN-1:0] edge_hit;
  always_comb
  begin
    for (int i = 0; i < N_IN; i++)
      edge_hit[i] = cfg_irq_select_in[i] &&
                    (falling_ff[i] ? (prev_ff[i] && !sync2_ff[i])
                                   : (!prev_ff[i] && sync2_ff[i]));
  end

  // ---------------------------------------------------------------
  // global enable
  // ---------------------------------------------------------------
  logic irq_en_ff;
  always_ff @(posedge clk_sys_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      irq_en_ff <= 1'b1;
    else if (global_irq_disable_command_in)
      irq_en_ff <= 1'b0;
    else if (global_irq_enable_command_in)
      irq_en_ff <= 1'b1;
  end

  // ---------------------------------------------------------------
  // counters
  // ---------------------------------------------------------------
  logic [CW-1:0]   cnt_ff [N_IN];
  logic [CW-1:0]   set_v  [N_IN];
  logic [N_IN-1:0] reach;
  logic [N_IN-1:0] pend_ff;
  logic [N_IN-1:0] fire;
  logic [N_IN-1:0] fire_grant;

  // every input is evaluated every cycle in parallel, far above 3 kHz
  always_comb
  begin
    for (int i = 0; i < N_IN; i++)
    begin
      set_v[i] = count_set_words_in[i*CW +: CW];
      reach[i] = 1'b0;
      if (edge_hit[i] && mode_ff[i] == MODE_COUNT_UP)
        reach[i] = (cnt_ff[i] + 16'h0001 == set_v[i]);
      else if (edge_hit[i] && mode_ff[i] == MODE_COUNT_DOWN)
        reach[i] = (cnt_ff[i] == 16'h0001);
      fire[i] = (edge_hit[i] && mode_ff[i] == MODE_DIRECT) ||
                ((reach[i] || pend_ff[i]) && irq_en_ff);
    end
  end

  // a mask-set command restarts the count from its starting value
  always_ff @(posedge clk_sys_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      for (int i = 0; i < N_IN; i++)
        cnt_ff[i] <= '0;
    end
    else
    begin
      for (int i = 0; i < N_IN; i++)
      begin
        if (interrupt_mask_set_command_in && mask_set_in.input_sel == 3'(i))
          cnt_ff[i] <= (mask_set_in.mode == MODE_COUNT_DOWN) ? set_v[i]
                                                             : '0;
        else if (reach[i])
          cnt_ff[i] <= (mode_ff[i] == MODE_COUNT_DOWN) ? set_v[i]
                                                       : '0;
        else if (edge_hit[i] && mode_ff[i] == MODE_COUNT_UP)
          cnt_ff[i] <= cnt_ff[i] + 16'h0001;
        else if (edge_hit[i] && mode_ff[i] == MODE_COUNT_DOWN)
          cnt_ff[i] <= cnt_ff[i] - 16'h0001;
      end
    end
  end

  // counter requests held while disabled, started after the enable
  always_ff @(posedge clk_sys_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      pend_ff <= '0;
    else
      pend_ff <= (pend_ff | reach) & ~fire_grant;
  end

  // ---------------------------------------------------------------
  // task start arbitration: lowest input wins, others are held until granted
  // ---------------------------------------------------------------
  logic [N_IN-1:0] direct_pend_ff;
  logic [N_IN-1:0] want;
  logic [2:0]      win;
  logic            any_win;

  always_comb
  begin
    want       = fire | direct_pend_ff;
    win        = '0;
    any_win    = 1'b0;
    fire_grant = '0;
    for (int i = N_IN - 1; i >= 0; i--)
      if (want[i])
      begin
        win     = 3'(i);
        any_win = 1'b1;
      end
    if (any_win)
      fire_grant[win] = 1'b1;
  end

  // direct requests that lose arbitration are not lost
  always_ff @(posedge clk_sys_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      direct_pend_ff <= '0;
    else
      direct_pend_ff <= (direct_pend_ff | (fire & ~pend_ff & ~reach))
                        & ~fire_grant;
  end

  always_ff @(posedge clk_sys_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      task_start_out <= 1'b0;
      task_info_out  <= '0;
    end
    else
    begin
      task_start_out          <= any_win;
      task_info_out.task_num  <= `IRQ_TASK_BASE + 8'(win);
      task_info_out.input_sel <= win;
    end
  end

  // ---------------------------------------------------------------
  // status copies and live read
  // ---------------------------------------------------------------
  logic [$clog2(SCAN)-1:0] scan_ff;
  logic                    scan_tick;
  assign scan_tick = (scan_ff == '0);

  always_ff @(posedge clk_sys_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      scan_ff <= '0;
    else
      scan_ff <= scan_tick ? ($clog2(SCAN))'(SCAN - 1) : scan_ff - 1'b1;
  end

  // status word changes irregularly: per scan and at each task start
  always_ff @(posedge clk_sys_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      count_present_words_out <= '0;
    else
      for (int i = 0; i < N_IN; i++)
        if (scan_tick || fire_grant[i])
          count_present_words_out[i*CW +: CW] <= cnt_ff[i];
  end

  always_ff @(posedge clk_sys_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      live_value_out       <= '0;
      live_value_valid_out <= 1'b0;
    end
    else
    begin
      live_value_valid_out <= live_value_read_command_in;
      if (live_value_read_command_in)
        live_value_out <= cnt_ff[live_value_sel_in];
    end
  end

  // ---------------------------------------------------------------
  // software latch
  // ---------------------------------------------------------------
  logic [N_IN*4-1:0] latch_src_ff;
  logic              src_loaded_ff;

  // sources taken once after reset release, so changes need a restart
  always_ff @(posedge clk_sys_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      latch_src_ff  <= '0;
      src_loaded_ff <= 1'b0;
    end
    else if (!src_loaded_ff)
    begin
      latch_src_ff  <= cfg_latch_src_in;
      src_loaded_ff <= 1'b1;
    end
  end

  // each input's slot with a source code of 1 to 8 takes the whole 32-bit source word at its task start
  always_ff @(posedge clk_sys_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      latch_store_words_out <= '0;
      latch_valid_out       <= '0;
    end
    else
      for (int i = 0; i < N_IN; i++)
      begin
        logic [3:0] s;
        s = latch_src_ff[i*4 +: 4];
        if (fire_grant[i] && s != `IRQ_LATCH_NONE && s <= `IRQ_LATCH_LAST)
        begin
          latch_store_words_out[i*32 +: 32] <=
            latch_source_values_in[(s - 4'h1)*32 +: 32];
          latch_valid_out[i] <= 1'b1;
        end
      end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_task_number_fixed: assert property (@(posedge clk_sys_in)
    disable iff (!reset_n_in) task_start_out |->
      task_info_out.task_num == 8'h8c + 8'(task_info_out.input_sel))
    else $error("task number not base plus input");

  a_disabled_no_start: assert property (@(posedge clk_sys_in)
    disable iff (!reset_n_in)
      (!irq_en_ff && (pend_ff | reach) != '0 && direct_pend_ff == '0 &&
       (edge_hit & {N_IN{1'b1}}) == '0) |=> !task_start_out)
    else $error("counter task started while disabled");

  a_up_reload: assert property (@(posedge clk_sys_in)
    disable iff (!reset_n_in)
      (reach[0] && mode_ff[0] == MODE_COUNT_UP &&
       !interrupt_mask_set_command_in) |=> cnt_ff[0] == '0)
    else $error("up counter not reloaded to zero");

  a_down_reload: assert property (@(posedge clk_sys_in)
    disable iff (!reset_n_in)
      (reach[0] && mode_ff[0] == MODE_COUNT_DOWN &&
       !interrupt_mask_set_command_in) |=> cnt_ff[0] == $past(set_v[0]))
    else $error("down counter not reloaded to set value");

  a_live_read: assert property (@(posedge clk_sys_in)
    disable iff (!reset_n_in)
      live_value_read_command_in |=>
        live_value_valid_out &&
        live_value_out == $past(cnt_ff[live_value_sel_in]))
    else $error("live read wrong");

  a_run_reload: assert property (@(posedge clk_sys_in)
    disable iff (!reset_n_in)
      (run_start && !interrupt_mask_set_command_in) |=>
        falling_ff == $past(cfg_edge_falling_in))
    else $error("edge config not reloaded");

  a_sync_edge: assert property (@(posedge clk_sys_in)
    disable iff (!reset_n_in)
      edge_hit[0] |-> (prev_ff[0] != sync2_ff[0]))
    else $error("edge without sample change");

  a_direct_start: assert property (@(posedge clk_sys_in)
    disable iff (!reset_n_in)
      (edge_hit[0] && mode_ff[0] == MODE_DIRECT) |=>
        task_start_out && task_info_out.input_sel == 3'h0)
    else $error("direct edge did not start task");

  a_scan_copy: assert property (@(posedge clk_sys_in)
    disable iff (!reset_n_in)
      scan_tick |=> count_present_words_out[CW-1:0] == $past(cnt_ff[0]))
    else $error("status copy missed");

  c_direct: cover property (@(posedge clk_sys_in)
    edge_hit[1] && mode_ff[1] == MODE_DIRECT);
  c_up_reach: cover property (@(posedge clk_sys_in)
    reach[2] && mode_ff[2] == MODE_COUNT_UP);
  c_down_reach: cover property (@(posedge clk_sys_in)
    reach[3] && mode_ff[3] == MODE_COUNT_DOWN);
  c_latched: cover property (@(posedge clk_sys_in) latch_valid_out[0]);

endmodule

// File: field_sensor_model.sv
// field sensor model: toggles one interrupt terminal a given number of times
// assumes the bench clock; terminal levels change on the falling edge only
`timescale 1ns/1ps
module field_sensor_model #(
  parameter int HALF = 4
)(
  // clock and command
  input  wire logic       clk_sys_in,
  input  wire logic       go_in,
  input  wire logic [2:0] sel_in,
  input  wire logic [7:0] edges_in,
  // terminal levels and status
  output logic [3:0]      module0_input_word_out,
  output logic [3:0]      module1_input_word_out,
  output logic            busy_out
);
  logic [7:0] pins_ff = 8'h00;

  // each level is held HALF cycles, long enough for the two-stage
  // synchroniser; faster chatter is not modelled
  initial busy_out = 1'b0;
  always
  begin
    @(negedge clk_sys_in);
    if (go_in)
    begin
      busy_out = 1'b1;
      for (int i = 0; i < int'(edges_in); i++)
      begin
        repeat (HALF) @(negedge clk_sys_in);
        pins_ff[sel_in] = ~pins_ff[sel_in];
      end
      busy_out = 1'b0;
    end
  end

  // terminal 0..3 on module 0, 4..7 on module 1
  assign module0_input_word_out = pins_ff[3:0];
  assign module1_input_word_out = pins_ff[7:4];
endmodule

// File: edge_interrupt_input_unit_tb_top.sv
// self-checking bench for the edge interrupt input unit
// assumes the field sensor model drives the terminals
`timescale 1ns/1ps
module edge_interrupt_input_unit_tb_top;
  import irq_input_pkg::*;
  logic          clk_sys_in = 1'b0;
  logic          reset_n_in = 1'b0;
  logic [7:0]    irq_sel = 8'hff;
  logic [7:0]    edge_fall = 8'h00;
  logic [31:0]   lat_src = 32'h0;
  logic [31:0]   lat_exp = 32'h0;
  logic          run_mode = 1'b0;
  logic [127:0]  set_words = '0;
  logic          msk_cmd = 1'b0;
  mask_set_cmd_t msk = '0;
  logic          dis_cmd = 1'b0;
  logic          en_cmd = 1'b0;
  logic          rd_cmd = 1'b0;
  logic [2:0]    rd_sel = 3'h0;
  logic [255:0]  lat_vals = '0;
  logic          go = 1'b0;
  logic [2:0]    go_sel = 3'h0;
  logic [7:0]    go_edges = 8'h00;
  logic [3:0]    pins0;
  logic [3:0]    pins1;
  logic          busy;
  logic          task_start;
  task_start_t   task_info;
  logic [127:0]  present;
  logic [15:0]   live;
  logic          live_valid;
  logic [255:0]  lat_words;
  logic [7:0]    lat_valid;
  task_start_t   seen_q[$];
  logic [15:0]   v;
  logic [3:0]    src;
  int            s;
  int            errors = 0;
  int            checks_done = 0;
  int            cycles = 0;

  always #5 clk_sys_in = ~clk_sys_in;

  field_sensor_model #(.HALF(4)) sensor_u (
    .clk_sys_in(clk_sys_in), .go_in(go), .sel_in(go_sel),
    .edges_in(go_edges), .module0_input_word_out(pins0),
    .module1_input_word_out(pins1), .busy_out(busy));

  // short status copy period keeps the run brief
  edge_interrupt_input_unit #(.SCAN(10)) dut_u (
    .clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in),
    .module0_input_word_in(pins0), .module1_input_word_in(pins1),
    .cfg_irq_select_in(irq_sel), .cfg_edge_falling_in(edge_fall),
    .cfg_latch_src_in(lat_src), .run_mode_in(run_mode),
    .count_set_words_in(set_words),
    .interrupt_mask_set_command_in(msk_cmd), .mask_set_in(msk),
    .global_irq_disable_command_in(dis_cmd),
    .global_irq_enable_command_in(en_cmd),
    .live_value_read_command_in(rd_cmd), .live_value_sel_in(rd_sel),
    .latch_source_values_in(lat_vals), .task_start_out(task_start),
    .task_info_out(task_info), .count_present_words_out(present),
    .live_value_out(live), .live_value_valid_out(live_valid),
    .latch_store_words_out(lat_words), .latch_valid_out(lat_valid));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // a started task is a one-cycle pulse, so it is logged at every falling edge
  always @(negedge clk_sys_in)
    if (task_start === 1'b1)
      seen_q.push_back(task_info);

  always @(posedge clk_sys_in)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      errors++;
      results();
    end
  end

  function automatic task_start_t exp_task(input int n);
    return task_start_t'{8'h8c + 8'(n), 3'(n)};
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      errors++;
      $display("wrong value at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  // clears the log, then toggles terminal n e times and lets it settle
  task automatic sense(input int n, input int e);
    seen_q.delete();
    @(negedge clk_sys_in);
    go <= 1'b1;
    go_sel <= 3'(n);
    go_edges <= 8'(e);
    @(negedge clk_sys_in);
    go <= 1'b0;
    @(posedge clk_sys_in);
    for (int i = 0; i < 2000 && busy; i++)
      @(posedge clk_sys_in);
    repeat (8) @(posedge clk_sys_in);
  endtask

  task automatic mask(input int n, input irq_mode_t m, input logic ev,
                      input logic ef);
    @(negedge clk_sys_in);
    msk_cmd <= 1'b1;
    msk <= mask_set_cmd_t'{3'(n), m, ev, ef};
    @(negedge clk_sys_in);
    msk_cmd <= 1'b0;
  endtask

  task automatic rd(input int n);
    v = 16'hxxxx;
    @(negedge clk_sys_in);
    rd_cmd <= 1'b1;
    rd_sel <= 3'(n);
    @(negedge clk_sys_in);
    rd_cmd <= 1'b0;
    for (int i = 0; i < 3; i++)
    begin
      if (live_valid === 1'b1)
        v = live;
      @(negedge clk_sys_in);
    end
  endtask

  task automatic results();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    void'($urandom(63197));
    for (int i = 0; i < 8; i++)
    begin
      lat_vals[32*i+:32] = $urandom();
      lat_exp[4*i+:4] = 4'($urandom_range(0, 9));
    end
    lat_src = lat_exp;
    repeat (12) @(negedge clk_sys_in);
    chk({task_start, live_valid, lat_valid, present[15:0]}, 0);
    reset_n_in <= 1'b1;
    @(negedge clk_sys_in);
    // sources changed after start-up must not take effect
    lat_src <= ~lat_exp;
    run_mode <= 1'b1;
    for (int n = 0; n < 8; n++)
    begin
      s = $urandom_range(1, 3);
      mask(n, MODE_DIRECT, 1'b1, 1'b0);
      sense(n, 2 * s);
      chk(seen_q.size(), s);
      chk(seen_q[0], exp_task(n));
      src = lat_exp[4*n+:4];
      chk(lat_valid[n], src inside {[1:8]});
      if (src inside {[1:8]})
        chk(lat_words[32*n+:32], lat_vals[32*(src-1)+:32]);
    end
    // falling edge picked by command while running
    mask(2, MODE_DIRECT, 1'b1, 1'b1);
    sense(2, 1);
    chk(seen_q.size(), 0);
    sense(2, 1);
    chk(seen_q.size(), 1);
    // up counting, set value written before the enabling command
    s = $urandom_range(2, 5);
    set_words[16+:16] <= 16'(s);
    mask(1, MODE_COUNT_UP, 1'b1, 1'b0);
    sense(1, 2 * (s - 1));
    chk(seen_q.size(), 0);
    rd(1);
    chk(v, s - 1);
    repeat (25) @(posedge clk_sys_in);
    chk(present[16+:16], s - 1);
    sense(1, 2);
    chk(seen_q.size(), 1);
    chk(seen_q[0], exp_task(1));
    sense(1, 2 * s);
    chk(seen_q.size(), 1);
    // reverse direction: mask, new set value, enable down
    mask(1, MODE_MASKED, 1'b0, 1'b0);
    s = $urandom_range(2, 5);
    set_words[16+:16] = 16'(s);
    mask(1, MODE_COUNT_DOWN, 1'b1, 1'b0);
    sense(1, 2);
    rd(1);
    chk(v, s - 1);
    sense(1, 2 * (s - 1));
    chk(seen_q.size(), 1);
    rd(1);
    chk(v, s);
    // largest set value counting down
    set_words[112+:16] = 16'hffff;
    mask(7, MODE_COUNT_DOWN, 1'b1, 1'b0);
    sense(7, 2);
    rd(7);
    chk(v, 16'hfffe);
    // globally disabled: counting goes on, task held back
    set_words[15:0] = 16'h0002;
    mask(0, MODE_COUNT_UP, 1'b1, 1'b0);
    @(negedge clk_sys_in);
    dis_cmd <= 1'b1;
    @(negedge clk_sys_in);
    dis_cmd <= 1'b0;
    sense(0, 2);
    rd(0);
    chk(v, 16'h0001);
    sense(0, 2);
    chk(seen_q.size(), 0);
    @(negedge clk_sys_in);
    en_cmd <= 1'b1;
    @(negedge clk_sys_in);
    en_cmd <= 1'b0;
    repeat (6) @(posedge clk_sys_in);
    chk(seen_q.size(), 1);
    // stored edge reloaded on the switch to run, used without edge
    edge_fall[5] <= 1'b1;
    @(negedge clk_sys_in);
    run_mode <= 1'b0;
    @(negedge clk_sys_in);
    run_mode <= 1'b1;
    mask(5, MODE_DIRECT, 1'b0, 1'b0);
    sense(5, 1);
    chk(seen_q.size(), 0);
    sense(5, 1);
    chk(seen_q.size(), 1);
    // masked input and a terminal given to another function
    mask(4, MODE_MASKED, 1'b0, 1'b0);
    sense(4, 2);
    chk(seen_q.size(), 0);
    irq_sel[3] <= 1'b0;
    sense(3, 2);
    chk(seen_q.size(), 0);
    results();
  end
endmodule
